// ==== hw/timer_pkg.sv ====
// register map, field layout and mode codes of the timer block
`default_nettype none
package timer_pkg;
  localparam logic [7:0] counter_ctrl_off = 8'h00;
  localparam logic [7:0] counter_value_off = 8'h04;
  localparam logic [7:0] prescaler_ctrl_off = 8'h08;
  localparam logic [7:0] channel_status_control_off = 8'h0c;
  localparam logic [7:0] channel_a_data_off = 8'h10;
  localparam logic [7:0] channel_b_data_off = 8'h14;

  // counter control fields
  localparam int clk_sel_lsb = 0;
  localparam int ext_edge_pos = 3;
  localparam int bus_sel_lsb = 4;
  localparam int ovf_ie_pos = 6;
  localparam int ovf_flag_pos = 7;
  localparam logic [2:0] clk_sel_ext = 3'h7;
  localparam logic [1:0] bus_none = 2'h0;
  localparam logic [1:0] bus_one = 2'h1;
  localparam logic [1:0] bus_two = 2'h2;
  localparam logic [1:0] bus_four = 2'h3;

  // prescaler control fields
  localparam int prescaler_run_pos = 0;
  localparam int prescaler_width = 7;

  // channel status/control fields
  localparam int mode_lsb = 0;
  localparam int edge_sel_lsb = 4;
  localparam int tb_sel_pos = 6;
  localparam int pin_level_pos = 7;
  localparam int ch_flag_pos = 8;
  localparam int ch_ie_pos = 9;
  localparam int out_pol_pos = 10;
  localparam logic [1:0] edge_rise = 2'h1;
  localparam logic [1:0] edge_fall = 2'h2;

  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] count_max = 16'hffff;
  localparam logic [15:0] data_reset = 16'h0000;

  localparam logic [3:0] mode_disabled = 4'h0;
  localparam logic [3:0] mode_pulse_width = 4'h1;
  localparam logic [3:0] mode_period = 4'h2;
  localparam logic [3:0] mode_plain_capture = 4'h3;
  localparam logic [3:0] mode_compare_flag_b = 4'h4;
  localparam logic [3:0] mode_compare_flag_ab = 4'h5;

  typedef enum logic {wait_leading, wait_trailing} pulse_state_type;
endpackage
`default_nettype wire

// ==== hw/timer_counter_and_double_action_channel.sv ====
// free-running counter, time-base buses and double action channel behind an apb slave
`default_nettype none
module timer_counter_and_double_action_channel #(
  parameter int count_width = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clock_pin,
  input wire logic channel_pin_in,
  output logic channel_pin_out,
  output logic channel_pin_oe,
  output logic [count_width-1:0] time_base_bus_one,
  output logic [count_width-1:0] time_base_bus_two,
  output logic [count_width-1:0] time_base_bus_four,
  output logic [count_width-1:0] free_running_counter,
  output logic overflow_irq,
  output logic channel_irq
);

  // pwm resolution mask from the low three mode bits
  function automatic logic [15:0] pwm_mask(input logic [2:0] code);
    case (code)
      3'h0: pwm_mask = 16'h007f;
      3'h1: pwm_mask = 16'h01ff;
      3'h2: pwm_mask = 16'h07ff;
      3'h3: pwm_mask = 16'h0fff;
      3'h4: pwm_mask = 16'h1fff;
      3'h5: pwm_mask = 16'h3fff;
      3'h6: pwm_mask = 16'h7fff;
      default: pwm_mask = 16'hffff;
    endcase
  endfunction

  // prescaler tap k pulses once every 2^(k+1) cycles
  function automatic logic tap_hit(input logic [timer_pkg::prescaler_width-1:0] div,
                                   input logic [2:0] k);
    logic [timer_pkg::prescaler_width-1:0] m;
    m = '0;
    for (int i = 0; i < timer_pkg::prescaler_width; i++) begin
      m[i] = (3'(i) <= k);
    end
    tap_hit = ((div & m) == m);
  endfunction

  logic [2:0] clk_sel_q;
  logic ext_edge_q;
  logic [1:0] bus_sel_q;
  logic ovf_ie_q;
  logic ovf_flag_q;
  logic run_q;
  logic [timer_pkg::prescaler_width-1:0] div_q;
  logic ext_q;
  logic ext_prev_q;
  logic [15:0] count_q;
  logic [3:0] mode_q;
  logic [1:0] edge_sel_q;
  logic tb_sel_q;
  logic ch_flag_q;
  logic ch_ie_q;
  logic out_pol_q;
  logic [15:0] a_data_q;
  logic [15:0] b_data_q;
  logic a_armed_q;
  logic b_armed_q;
  logic pin_q;
  logic pin_prev_q;
  logic ff_q;
  logic period_first_q;
  timer_pkg::pulse_state_type pulse_q;

  logic wr_en;
  logic rd_setup;
  logic count_tick;
  logic overflow;
  logic [15:0] tb;
  logic rise;
  logic fall;
  logic sel_edge;
  logic is_compare;
  logic is_pwm;
  logic drives_pin;
  logic match_a;
  logic match_b;
  logic cap_event;
  logic ch_event;
  logic [15:0] mask;
  logic [31:0] rd_value;
  logic rd_ok;

  assign wr_en = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;

  // apb slave: one wait-free access phase
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr)
      timer_pkg::counter_ctrl_off: begin
        rd_value[timer_pkg::clk_sel_lsb +: 3] = clk_sel_q;
        rd_value[timer_pkg::ext_edge_pos] = ext_edge_q;
        rd_value[timer_pkg::bus_sel_lsb +: 2] = bus_sel_q;
        rd_value[timer_pkg::ovf_ie_pos] = ovf_ie_q;
        rd_value[timer_pkg::ovf_flag_pos] = ovf_flag_q;
      end
      timer_pkg::counter_value_off: rd_value[15:0] = count_q;
      timer_pkg::prescaler_ctrl_off: rd_value[timer_pkg::prescaler_run_pos] = run_q;
      timer_pkg::channel_status_control_off: begin
        rd_value[timer_pkg::mode_lsb +: 4] = mode_q;
        rd_value[timer_pkg::edge_sel_lsb +: 2] = edge_sel_q;
        rd_value[timer_pkg::tb_sel_pos] = tb_sel_q;
        rd_value[timer_pkg::pin_level_pos] = pin_q;
        rd_value[timer_pkg::ch_flag_pos] = ch_flag_q;
        rd_value[timer_pkg::ch_ie_pos] = ch_ie_q;
        rd_value[timer_pkg::out_pol_pos] = out_pol_q;
      end
      timer_pkg::channel_a_data_off: rd_value[15:0] = a_data_q;
      timer_pkg::channel_b_data_off: rd_value[15:0] = b_data_q;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr <= ~rd_ok;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // counter control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_q <= 3'h0;
      ext_edge_q <= 1'b0;
      bus_sel_q <= timer_pkg::bus_none;
      ovf_ie_q <= 1'b0;
      run_q <= 1'b0;
    end else if (wr_en && paddr == timer_pkg::counter_ctrl_off) begin
      clk_sel_q <= pwdata[timer_pkg::clk_sel_lsb +: 3];
      ext_edge_q <= pwdata[timer_pkg::ext_edge_pos];
      bus_sel_q <= pwdata[timer_pkg::bus_sel_lsb +: 2];
      ovf_ie_q <= pwdata[timer_pkg::ovf_ie_pos];
    end else if (wr_en && paddr == timer_pkg::prescaler_ctrl_off) begin
      run_q <= pwdata[timer_pkg::prescaler_run_pos];
    end
  end

  // prescaler divider and external clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      ext_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      // divider holds while stopped so all counters start in step
      if (run_q) begin
        div_q <= div_q + 1'b1;
      end
      ext_q <= ext_clock_pin;
      ext_prev_q <= ext_q;
    end
  end

  always_comb begin
    if (clk_sel_q == timer_pkg::clk_sel_ext) begin
      // ext_edge_q high counts falling edges of the pin
      count_tick = run_q & (ext_edge_q ? (ext_prev_q & ~ext_q) : (~ext_prev_q & ext_q));
    end else begin
      count_tick = run_q & tap_hit(div_q, clk_sel_q);
    end
  end

  assign overflow = count_tick & (count_q == timer_pkg::count_max);

  // free-running counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= timer_pkg::count_reset;
    end else if (count_tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_q <= 1'b0;
    end else if (overflow) begin
      ovf_flag_q <= 1'b1;
    end else if (wr_en && paddr == timer_pkg::counter_ctrl_off && pwdata[timer_pkg::ovf_flag_pos]) begin
      ovf_flag_q <= 1'b0;
    end
  end

  // time-base buses and primary output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_base_bus_one <= '0;
      time_base_bus_two <= '0;
      time_base_bus_four <= '0;
      free_running_counter <= '0;
      overflow_irq <= 1'b0;
    end else begin
      // undriven buses read zero; no other counter source exists here
      time_base_bus_one <= (bus_sel_q == timer_pkg::bus_one) ? count_q : '0;
      time_base_bus_two <= (bus_sel_q == timer_pkg::bus_two) ? count_q : '0;
      time_base_bus_four <= (bus_sel_q == timer_pkg::bus_four) ? count_q : '0;
      free_running_counter <= count_q;
      overflow_irq <= ovf_flag_q & ovf_ie_q;
    end
  end

  // channel decode
  assign tb = tb_sel_q ? time_base_bus_two : time_base_bus_one;
  assign rise = pin_q & ~pin_prev_q;
  assign fall = ~pin_q & pin_prev_q;
  assign sel_edge = (edge_sel_q[0] & rise) | (edge_sel_q[1] & fall);
  assign is_pwm = mode_q[3];
  assign is_compare = (mode_q == timer_pkg::mode_compare_flag_b) ||
                      (mode_q == timer_pkg::mode_compare_flag_ab);
  assign drives_pin = is_pwm | is_compare;
  assign mask = pwm_mask(mode_q[2:0]);

  always_comb begin
    if (is_pwm) begin
      match_a = ((tb & mask) == (a_data_q & mask));
      match_b = ((tb & mask) == (b_data_q & mask));
    end else begin
      match_a = is_compare & a_armed_q & (tb == a_data_q);
      match_b = is_compare & b_armed_q & (tb == b_data_q);
    end
  end

  always_comb begin
    cap_event = 1'b0;
    case (mode_q)
      timer_pkg::mode_pulse_width: cap_event = (pulse_q == timer_pkg::wait_trailing) &&
                                               (edge_sel_q[0] ? fall : rise);
      timer_pkg::mode_period: cap_event = sel_edge & ~period_first_q;
      timer_pkg::mode_plain_capture: cap_event = sel_edge;
      default: cap_event = 1'b0;
    endcase
  end

  always_comb begin
    if (mode_q == timer_pkg::mode_compare_flag_ab) begin
      ch_event = match_a | match_b;
    end else if (mode_q == timer_pkg::mode_compare_flag_b || is_pwm) begin
      ch_event = match_b;
    end else begin
      ch_event = cap_event;
    end
  end

  // channel status/control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= timer_pkg::mode_disabled;
      edge_sel_q <= timer_pkg::edge_rise;
      tb_sel_q <= 1'b0;
      ch_ie_q <= 1'b0;
      out_pol_q <= 1'b0;
    end else if (wr_en && paddr == timer_pkg::channel_status_control_off) begin
      mode_q <= pwdata[timer_pkg::mode_lsb +: 4];
      edge_sel_q <= pwdata[timer_pkg::edge_sel_lsb +: 2];
      tb_sel_q <= pwdata[timer_pkg::tb_sel_pos];
      ch_ie_q <= pwdata[timer_pkg::ch_ie_pos];
      out_pol_q <= pwdata[timer_pkg::out_pol_pos];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_flag_q <= 1'b0;
    end else if (ch_event) begin
      ch_flag_q <= 1'b1;
    end else if (wr_en && paddr == timer_pkg::channel_status_control_off && pwdata[timer_pkg::ch_flag_pos]) begin
      ch_flag_q <= 1'b0;
    end
  end

  // input edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_q <= channel_pin_in;
      pin_prev_q <= pin_q;
    end
  end

  // pulse width sequencer: leading edge then trailing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= timer_pkg::wait_leading;
    end else if (mode_q != timer_pkg::mode_pulse_width) begin
      pulse_q <= timer_pkg::wait_leading;
    end else begin
      case (pulse_q)
        timer_pkg::wait_leading: if (edge_sel_q[0] ? rise : fall) pulse_q <= timer_pkg::wait_trailing;
        timer_pkg::wait_trailing: if (cap_event) pulse_q <= timer_pkg::wait_leading;
        default: pulse_q <= timer_pkg::wait_leading;
      endcase
    end
  end

  // first period edge only primes the measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_first_q <= 1'b1;
    end else if (mode_q != timer_pkg::mode_period) begin
      period_first_q <= 1'b1;
    end else if (sel_edge) begin
      period_first_q <= 1'b0;
    end
  end

  // channel data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_data_q <= timer_pkg::data_reset;
      b_data_q <= timer_pkg::data_reset;
    end else begin
      if (mode_q == timer_pkg::mode_pulse_width && pulse_q == timer_pkg::wait_leading &&
          (edge_sel_q[0] ? rise : fall)) begin
        b_data_q <= tb;
      end else if (mode_q == timer_pkg::mode_period && sel_edge) begin
        b_data_q <= a_data_q;
      end else if (wr_en && paddr == timer_pkg::channel_b_data_off) begin
        b_data_q <= pwdata[15:0];
      end
      if (cap_event || (mode_q == timer_pkg::mode_period && sel_edge)) begin
        a_data_q <= tb;
      end else if (wr_en && paddr == timer_pkg::channel_a_data_off) begin
        a_data_q <= pwdata[15:0];
      end
    end
  end

  // software writes in a compare mode arm a comparator until it matches once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_armed_q <= 1'b0;
      b_armed_q <= 1'b0;
    end else begin
      if (wr_en && paddr == timer_pkg::channel_a_data_off && is_compare) begin
        a_armed_q <= 1'b1;
      end else if (match_a && !is_pwm) begin
        a_armed_q <= 1'b0;
      end
      if (wr_en && paddr == timer_pkg::channel_b_data_off && is_compare) begin
        b_armed_q <= 1'b1;
      end else if (match_b && !is_pwm) begin
        b_armed_q <= 1'b0;
      end
    end
  end

  // output flip-flop and pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_q <= 1'b0;
    end else if (!drives_pin) begin
      ff_q <= 1'b0;
    end else if (match_a) begin
      ff_q <= 1'b1;
    end else if (match_b) begin
      ff_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_pin_out <= 1'b0;
      channel_pin_oe <= 1'b0;
      channel_irq <= 1'b0;
    end else begin
      channel_pin_out <= drives_pin & (ff_q ^ out_pol_q);
      channel_pin_oe <= drives_pin;
      channel_irq <= ch_flag_q & ch_ie_q;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/timer_props.sv ====
// concurrent checks on the timer block ports
`default_nettype none
module timer_props #(
  parameter int count_width = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic channel_pin_oe,
  input wire logic [count_width-1:0] time_base_bus_one,
  input wire logic [count_width-1:0] time_base_bus_two,
  input wire logic [count_width-1:0] time_base_bus_four,
  input wire logic [count_width-1:0] free_running_counter,
  input wire logic overflow_irq,
  input wire logic channel_irq
);
  logic wr;
  logic off;
  logic run_q;
  logic wrap_q;
  logic oie_q;
  logic cie_q;
  logic [3:0] mode_q;
  assign wr = psel && penable && pready && pwrite;
  // reserved codes leave the pin floating just like the disabled code
  assign off = mode_q == 4'h0 || mode_q[3:1] == 3'h3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      wrap_q <= 1'b0;
      oie_q <= 1'b0;
      cie_q <= 1'b0;
      mode_q <= 4'h0;
    end else begin
      if (&free_running_counter) wrap_q <= 1'b1;
      if (wr && paddr == 8'h08 && pwdata[0]) run_q <= 1'b1;
      if (wr && paddr == 8'h00) oie_q <= pwdata[6];
      if (wr && paddr == 8'h0c) begin
        cie_q <= pwdata[9];
        mode_q <= pwdata[3:0];
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  unmapped_refused_a: assert property (psel && !penable && paddr > 8'h14 |=> pready && pslverr && prdata == 0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && !penable && paddr <= 8'h14 && paddr[1:0] == 2'h0 |=> pready && !pslverr)
    else $error("mapped access refused");
  one_bus_a: assert property ($onehot0({|time_base_bus_one, |time_base_bus_two, |time_base_bus_four}))
    else $error("more than one time base bus driven");
  bus_copy_a: assert property (|time_base_bus_one |-> time_base_bus_one == free_running_counter)
    else $error("time base bus differs from counter");
  count_step_a: assert property (free_running_counter != $past(free_running_counter)
    |-> free_running_counter == $past(free_running_counter) + 1'b1)
    else $error("counter moved by other than one");
  held_stop_a: assert property (!run_q |-> free_running_counter == 0)
    else $error("counter moved before run bit");
  ovf_quiet_a: assert property (!wrap_q |-> !overflow_irq)
    else $error("overflow request without wrap");
  ovf_gate_a: assert property (overflow_irq |-> $past(oie_q))
    else $error("overflow request while disabled");
  ch_gate_a: assert property (channel_irq |-> $past(cie_q))
    else $error("channel request while disabled");
  pin_float_a: assert property (off [*3] |-> !channel_pin_oe)
    else $error("pin driven while channel off");
endmodule
bind timer_counter_and_double_action_channel timer_props #(.count_width(count_width)) props_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_pin_oe(channel_pin_oe),
  .time_base_bus_one(time_base_bus_one), .time_base_bus_two(time_base_bus_two),
  .time_base_bus_four(time_base_bus_four), .free_running_counter(free_running_counter),
  .overflow_irq(overflow_irq), .channel_irq(channel_irq));
`default_nettype wire

// ==== testbench/pin_source.sv ====
// pin-side model: external count clock and channel pin level
`default_nettype none
module pin_source (
  input wire logic pclk,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic ext_clock_pin,
  output logic pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic level_q;
  initial begin
    ext_clock_pin = 1'b0;
    level_q = 1'b0;
  end
  // the wire shows the channel's drive whenever it drives, else our level
  assign pin_in = pin_oe ? pin_out : level_q;
  task automatic pulses(input int n);
    repeat (n) begin
      ext_clock_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_clock_pin <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask
  task automatic level(input logic v);
    level_q <= v;
    repeat (4) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== testbench/timer_counter_and_double_action_channel_bench.sv ====
// self-checking bench for the timer block
`default_nettype none
module timer_counter_and_double_action_channel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic rd; logic [31:0] d; logic e; string n;} note_type;
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, ext_clock_pin, channel_pin_in, channel_pin_out, channel_pin_oe;
  logic overflow_irq, channel_irq;
  logic [15:0] tb1, tb2, tb4, frc;
  logic [15:0] cnt = 16'h0;
  note_type q[$];
  int n_errors = 0;
  int check_count = 0;
  always #2 pclk = ~pclk;
  timer_counter_and_double_action_channel #(.count_width(16)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
    .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
    .time_base_bus_one(tb1), .time_base_bus_two(tb2), .time_base_bus_four(tb4),
    .free_running_counter(frc), .overflow_irq(overflow_irq), .channel_irq(channel_irq));
  pin_source ps (.pclk(pclk), .pin_out(channel_pin_out), .pin_oe(channel_pin_oe),
    .ext_clock_pin(ext_clock_pin), .pin_in(channel_pin_in));
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask
  // results are judged where they appear, against notes left by the driver
  always @(posedge pclk) begin
    note_type nt;
    if (psel && penable && pready === 1'b1) begin
      nt = q.pop_front();
      cmp_bit({nt.n, " pslverr"}, nt.e, pslverr);
      if (nt.rd) cmp_word(nt.n, nt.d, prdata);
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    q.push_back('{!w, d, a > 8'h14, $sformatf("apb %h", a)});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      cmp_bit("pready wait", 1'b1, pready);
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // s selects the watched output: 0 channel request, 1 pin output
  task automatic wait_for(input int s, input logic v);
    int k;
    k = 0;
    while ((s ? channel_pin_out : channel_irq) !== v && k < 60) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 60) begin
      cmp_bit("output wait", v, s ? channel_pin_out : channel_irq);
      summarize();
    end
  endtask
  task automatic step(input int n);
    ps.pulses(n);
    cnt = cnt + n[15:0];
  endtask
  initial begin
    int n;
    logic [15:0] lead;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n = $urandom(3);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // channel control resets to disabled with rising-edge select, so that word is not zero
    for (int a = 0; a < 32; a += 4) apb(1'b0, a[7:0], (a == 12) ? 32'h0000_0010 : 32'h0);
    apb(1'b1, 8'h18, 32'hffffffff);
    $display("registers test done");
    apb(1'b1, 8'h00, 32'h17);
    ps.pulses(3);
    apb(1'b0, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'hffffffff);
    apb(1'b0, 8'h08, 32'h1);
    step($urandom_range(15, 1));
    apb(1'b0, 8'h04, {16'h0, cnt});
    apb(1'b0, 8'h00, 32'h17);
    cmp_word("free_running_counter", {16'h0, cnt}, {16'h0, frc});
    cmp_word("time_base_bus_one", {16'h0, cnt}, {16'h0, tb1});
    cmp_word("time_base_bus_four", 32'h0, {16'h0, tb4});
    $display("counter test done");
    apb(1'b1, 8'h0c, 32'h213);
    ps.level(1'b1);
    wait_for(0, 1'b1);
    apb(1'b0, 8'h10, {16'h0, cnt});
    apb(1'b1, 8'h0c, 32'h113);
    wait_for(0, 1'b0);
    step(2);
    ps.level(1'b0);
    apb(1'b0, 8'h0c, 32'h13);
    $display("capture test done");
    apb(1'b1, 8'h0c, 32'h211);
    step(2);
    ps.level(1'b1);
    lead = cnt;
    apb(1'b0, 8'h0c, 32'h291);
    step($urandom_range(9, 1));
    ps.level(1'b0);
    wait_for(0, 1'b1);
    apb(1'b0, 8'h14, {16'h0, lead});
    apb(1'b0, 8'h10, {16'h0, cnt});
    $display("pulse width test done");
    apb(1'b1, 8'h0c, 32'h312);
    wait_for(0, 1'b0);
    step(1);
    ps.level(1'b1);
    apb(1'b0, 8'h0c, 32'h292);
    lead = cnt;
    step($urandom_range(6, 1));
    ps.level(1'b0);
    step(2);
    ps.level(1'b1);
    wait_for(0, 1'b1);
    apb(1'b0, 8'h10, {16'h0, cnt});
    apb(1'b0, 8'h14, {16'h0, lead});
    $display("period test done");
    for (int m = 4; m < 6; m++) begin
      apb(1'b1, 8'h0c, 32'h300 | m);
      wait_for(0, 1'b0);
      apb(1'b1, 8'h10, {16'h0, cnt + 16'h2});
      apb(1'b1, 8'h14, {16'h0, cnt + 16'h4});
      step(2);
      wait_for(1, 1'b1);
      cmp_bit("pin_oe", 1'b1, channel_pin_oe);
      apb(1'b0, 8'h0c, 32'h280 | m | (m == 5 ? 32'h100 : 32'h0));
      step(2);
      wait_for(1, 1'b0);
      wait_for(0, 1'b1);
      apb(1'b0, 8'h0c, 32'h300 | m);
    end
    $display("compare test done");
    apb(1'b1, 8'h0c, 32'h100);
    ps.level(1'b1);
    apb(1'b0, 8'h0c, 32'h80);
    cmp_bit("pin_oe", 1'b0, channel_pin_oe);
    $display("disabled test done");
    // counter moves to bus two; the channel follows it there
    apb(1'b1, 8'h00, 32'h27);
    @(posedge pclk);
    cmp_word("time_base_bus_two", {16'h0, cnt}, {16'h0, tb2});
    cmp_word("time_base_bus_one", 32'h0, {16'h0, tb1});
    // load the edges while disabled so no stale match fires on mode entry
    apb(1'b1, 8'h10, {16'h0, cnt + 16'h2});
    apb(1'b1, 8'h14, {16'h0, cnt + 16'h4});
    apb(1'b1, 8'h0c, 32'h348);
    step(2);
    wait_for(1, 1'b1);
    cmp_bit("pin_oe", 1'b1, channel_pin_oe);
    step(2);
    wait_for(1, 1'b0);
    wait_for(0, 1'b1);
    cmp_bit("overflow_irq", 1'b0, overflow_irq);
    $display("pwm test done");
    summarize();
  end
endmodule
`default_nettype wire
